// file: rtl/eur_rx.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Sample the line sixteen times per bit; shift one data bit per bit period.
// - Bit rate comes from the divisor, 16-bit with width select set and low byte only otherwise, scaled by speed and width selects.
// - Asynchronous reception only while sync select clear and port enabled.
// - Nine data bits when nine-bit enable set; ninth bit shown in status.
// - Characters accepted only while continuous receive enable is set.
// - Completion sets receive flag; interrupt request when enable also set.
// - Low eight data bits returned by reading the receive data register.
// - Clearing continuous receive enable clears latched reception errors.
// - Address detection applies to nine-bit reception while enabled.
// - Address detect off: every character loaded and flagged while the receive flag is clear and no overrun is latched.
// - While asleep the baud generator halts; no normal reception.
// - Wake-up enable suspends normal reception; receiver idles watching line.
// - Falling edge on the line is the wake-up event while armed.
// - Wake-up event sets the receive-complete flag.
// - Reading receive data register clears the wake-induced flag.
// - First rising edge after wake event clears wake-up enable; reception resumes.
// - Frame is start bit, eight or nine data bits LSB first, one stop bit.
module eur_rx (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial line and power state
	input wire logic serial_rx_line,
	input wire logic cpu_sleep,
	// Receive interrupt request
	output logic rx_irq
);
	import eur_pkg::*;

	eur_cfg_s cfg_q;
	logic sren_q;
	logic [7:0] div_hi_q;
	logic [7:0] div_lo_q;
	eur_char_s buf_q;
	logic rx_flag_q;
	logic overrun_q;
	eur_state_e state_q;
	logic [3:0] phase_q;
	logic [3:0] bitn_q;
	logic [8:0] shift_q;
	logic [2:0] samp_q;
	logic [EUR_PER_W-1:0] bcnt_q;
	logic rx_prev_q;
	logic woke_q;
	logic [EUR_ADDR_W-1:0] waddr_q;
	logic wr_pend_q;
	logic [31:0] hrdata_q;

	logic acc;
	logic rd_acc;
	logic wr_now;
	logic data_read;
	logic async_on;
	logic rx_run;
	logic tick;
	logic [EUR_PER_W-1:0] n1;
	logic [EUR_PER_W-1:0] per;
	logic [EUR_PER_W-1:0] reload;
	logic vote;
	logic mid;
	logic last_bit;
	logic stop_done;
	logic addr_mode;
	logic [7:0] got_data;
	logic got_ninth;
	logic keep_char;
	logic load_char;
	logic fall;
	logic rise;
	logic wake_set;
	logic wake_done;
	logic [7:0] rcv_stat;
	logic [7:0] tx_stat;
	logic [7:0] baud_ctl;
	logic [7:0] int_ctl;
	logic [31:0] rd_mux;

	// Bus decode: zero-wait slave, always OKAY
	assign acc = hsel & hready & htrans[1];
	assign rd_acc = acc & ~hwrite;
	assign wr_now = wr_pend_q;
	assign data_read = rd_acc & (haddr[EUR_ADDR_W-1:0] == EUR_OFS_RCV_DATA);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Write address is held so the write lands at the end of the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			waddr_q <= '0;
		end else begin
			wr_pend_q <= acc & hwrite;
			if (acc) begin
				waddr_q <= haddr[EUR_ADDR_W-1:0];
			end
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q.port_enable <= EUR_RST_RCV_STAT[EUR_RS_PORT_EN];
			cfg_q.rx_nine_bit_enable <= EUR_RST_RCV_STAT[EUR_RS_NINE];
			cfg_q.continuous_rx_enable <= EUR_RST_RCV_STAT[EUR_RS_CONTINUOUS_RX_ENABLE];
			cfg_q.address_detect_enable <= EUR_RST_RCV_STAT[EUR_RS_ADDRESS_DETECT_ENABLE];
			sren_q <= EUR_RST_RCV_STAT[EUR_RS_SREN];
			cfg_q.sync_mode <= EUR_RST_TX_STAT[EUR_TS_SYNC];
			cfg_q.high_speed_baud <= EUR_RST_TX_STAT[EUR_TS_HSPD];
			cfg_q.wide_divisor_select <= EUR_RST_BAUD_CTL[EUR_BC_WIDE];
			cfg_q.rx_int_enable <= 1'b0;
			div_hi_q <= EUR_RST_DIV;
			div_lo_q <= EUR_RST_DIV;
		end else if (wr_now) begin
			case (waddr_q)
				EUR_OFS_RCV_STAT: begin
					cfg_q.port_enable <= hwdata[EUR_RS_PORT_EN];
					cfg_q.rx_nine_bit_enable <= hwdata[EUR_RS_NINE];
					cfg_q.continuous_rx_enable <= hwdata[EUR_RS_CONTINUOUS_RX_ENABLE];
					cfg_q.address_detect_enable <= hwdata[EUR_RS_ADDRESS_DETECT_ENABLE];
					sren_q <= hwdata[EUR_RS_SREN];
				end
				EUR_OFS_TX_STAT: begin
					cfg_q.sync_mode <= hwdata[EUR_TS_SYNC];
					cfg_q.high_speed_baud <= hwdata[EUR_TS_HSPD];
				end
				EUR_OFS_BAUD_CTL: begin
					cfg_q.wide_divisor_select <= hwdata[EUR_BC_WIDE];
				end
				EUR_OFS_DIV_HI: begin
					div_hi_q <= hwdata[7:0];
				end
				EUR_OFS_DIV_LO: begin
					div_lo_q <= hwdata[7:0];
				end
				EUR_OFS_INT_CTL: begin
					cfg_q.rx_int_enable <= hwdata[EUR_IC_IE];
				end
				default: begin
				end
			endcase
		end
	end

	// Wake-up enable: software sets or clears it, hardware clears it after the break
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q.wakeup_enable <= EUR_RST_BAUD_CTL[EUR_BC_WAKE];
		end else if (wr_now && waddr_q == EUR_OFS_BAUD_CTL) begin
			cfg_q.wakeup_enable <= hwdata[EUR_BC_WAKE];
		end else if (wake_done) begin
			cfg_q.wakeup_enable <= 1'b0;
		end
	end

	assign async_on = cfg_q.port_enable & ~cfg_q.sync_mode;
	// Normal reception is held off by wake-up mode, sleep, or a latched overrun
	assign rx_run = async_on & cfg_q.continuous_rx_enable & ~cfg_q.wakeup_enable & ~cpu_sleep
		& ~overrun_q;

	// Baud generator: one sampling tick per sixteenth of a bit
	assign n1 = {2'b00, (cfg_q.wide_divisor_select ? div_hi_q : 8'h00), div_lo_q} + 18'd1;
	// Both selects with a tiny divisor clamp to one clock per tick
	always_comb begin
		case ({cfg_q.wide_divisor_select, cfg_q.high_speed_baud})
			2'b00: per = {n1[EUR_PER_W-3:0], 2'b00};
			2'b11: per = (n1[EUR_PER_W-1:2] == '0) ? 18'd1 : {2'b00, n1[EUR_PER_W-1:2]};
			default: per = n1;
		endcase
	end
	assign reload = per - 18'd1;
	assign tick = rx_run & (bcnt_q == '0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bcnt_q <= '0;
		end else if (!rx_run) begin
			bcnt_q <= '0;
		end else if (bcnt_q == '0) begin
			bcnt_q <= reload;
		end else begin
			bcnt_q <= bcnt_q - 18'd1;
		end
	end

	// Sampling shifter and majority vote of three samples around mid-bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			samp_q <= 3'h7;
		end else if (tick) begin
			samp_q <= {samp_q[1:0], serial_rx_line};
		end
	end
	assign vote = (samp_q[1] & samp_q[0]) | (samp_q[1] & serial_rx_line) | (samp_q[0] & serial_rx_line);
	assign mid = tick & (phase_q == EUR_MID_TICK);
	assign last_bit = bitn_q == (cfg_q.rx_nine_bit_enable ? EUR_LAST_BIT_9 : EUR_LAST_BIT_8);
	assign stop_done = mid & (state_q == EUR_ST_STOP);

	// Receive state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= EUR_ST_IDLE;
			phase_q <= '0;
			bitn_q <= '0;
		end else if (!rx_run) begin
			state_q <= EUR_ST_IDLE;
			phase_q <= '0;
			bitn_q <= '0;
		end else if (tick) begin
			phase_q <= phase_q + 4'h1;
			case (state_q)
				EUR_ST_IDLE: begin
					phase_q <= EUR_FIRST_PHASE;
					if (!serial_rx_line) begin
						state_q <= EUR_ST_START;
					end
				end
				EUR_ST_START: begin
					if (mid) begin
						state_q <= vote ? EUR_ST_IDLE : EUR_ST_DATA;
						bitn_q <= '0;
					end
				end
				EUR_ST_DATA: begin
					if (mid) begin
						bitn_q <= bitn_q + 4'h1;
						if (last_bit) begin
							state_q <= EUR_ST_STOP;
						end
					end
				end
				EUR_ST_STOP: begin
					if (mid) begin
						state_q <= EUR_ST_IDLE;
					end
				end
				default: begin
					state_q <= EUR_ST_IDLE;
				end
			endcase
		end
	end

	// Receive shifter, least significant bit first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shift_q <= '0;
		end else if (mid && state_q == EUR_ST_DATA) begin
			shift_q <= {vote, shift_q[8:1]};
		end
	end

	always_comb begin
		if (cfg_q.rx_nine_bit_enable) begin
			got_data = shift_q[7:0];
			got_ninth = shift_q[8];
		end else begin
			got_data = shift_q[8:1];
			got_ninth = 1'b0;
		end
	end

	assign addr_mode = cfg_q.address_detect_enable & cfg_q.rx_nine_bit_enable;
	assign keep_char = ~addr_mode | got_ninth;
	assign load_char = stop_done & keep_char & ~rx_flag_q;

	// Receive buffer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			buf_q <= '0;
		end else if (load_char) begin
			buf_q.data <= got_data;
			buf_q.rx_ninth_bit <= got_ninth;
			buf_q.framing_error <= ~vote;
		end else if (!cfg_q.continuous_rx_enable) begin
			buf_q.framing_error <= 1'b0;
		end
	end

	// Overrun: a kept character completes while the buffer is still full
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			overrun_q <= 1'b0;
		end else if (!cfg_q.continuous_rx_enable) begin
			overrun_q <= 1'b0;
		end else if (stop_done && keep_char && rx_flag_q) begin
			overrun_q <= 1'b1;
		end
	end

	// Wake-up: falling edge arms, following rising edge finishes
	assign fall = rx_prev_q & ~serial_rx_line;
	assign rise = ~rx_prev_q & serial_rx_line;
	assign wake_set = async_on & cfg_q.wakeup_enable & ~woke_q & fall;
	assign wake_done = async_on & cfg_q.wakeup_enable & woke_q & rise;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Reset to the idle level so no false edge follows reset
			rx_prev_q <= 1'b1;
			woke_q <= 1'b0;
		end else begin
			rx_prev_q <= serial_rx_line;
			if (!cfg_q.wakeup_enable || !async_on || wake_done) begin
				woke_q <= 1'b0;
			end else if (wake_set) begin
				woke_q <= 1'b1;
			end
		end
	end

	// Receive-complete flag: a new set wins over a read in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_flag_q <= 1'b0;
		end else if (load_char || wake_set) begin
			rx_flag_q <= 1'b1;
		end else if (data_read) begin
			rx_flag_q <= 1'b0;
		end
	end

	assign rx_irq = rx_flag_q & cfg_q.rx_int_enable;

	// Read views
	assign rcv_stat = {cfg_q.port_enable, cfg_q.rx_nine_bit_enable, sren_q, cfg_q.continuous_rx_enable,
		cfg_q.address_detect_enable, buf_q.framing_error, overrun_q, buf_q.rx_ninth_bit};
	assign tx_stat = {3'b000, cfg_q.sync_mode, 1'b0, cfg_q.high_speed_baud, 2'b00};
	assign baud_ctl = {1'b0, (state_q == EUR_ST_IDLE), 1'b0, 1'b0, cfg_q.wide_divisor_select, 1'b0,
		cfg_q.wakeup_enable, 1'b0};
	assign int_ctl = {6'h00, rx_flag_q, cfg_q.rx_int_enable};

	always_comb begin
		case (haddr[EUR_ADDR_W-1:0])
			EUR_OFS_RCV_STAT: rd_mux = {24'h000000, rcv_stat};
			EUR_OFS_RCV_DATA: rd_mux = {24'h000000, buf_q.data};
			EUR_OFS_TX_STAT: rd_mux = {24'h000000, tx_stat};
			EUR_OFS_BAUD_CTL: rd_mux = {24'h000000, baud_ctl};
			EUR_OFS_DIV_HI: rd_mux = {24'h000000, div_hi_q};
			EUR_OFS_DIV_LO: rd_mux = {24'h000000, div_lo_q};
			EUR_OFS_INT_CTL: rd_mux = {24'h000000, int_ctl};
			default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data is captured at the address phase and stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_acc) begin
			hrdata_q <= rd_mux;
		end
	end
endmodule

// file: rtl/eur_pkg.sv
package eur_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] EUR_OFS_RCV_STAT = 8'h00;
	localparam logic [7:0] EUR_OFS_RCV_DATA = 8'h04;
	localparam logic [7:0] EUR_OFS_TX_STAT = 8'h08;
	localparam logic [7:0] EUR_OFS_BAUD_CTL = 8'h0c;
	localparam logic [7:0] EUR_OFS_DIV_HI = 8'h10;
	localparam logic [7:0] EUR_OFS_DIV_LO = 8'h14;
	localparam logic [7:0] EUR_OFS_INT_CTL = 8'h18;
	localparam int EUR_ADDR_W = 8;

	// receive_status_control fields
	localparam int EUR_RS_PORT_EN = 7;
	localparam int EUR_RS_NINE = 6;
	localparam int EUR_RS_SREN = 5;
	localparam int EUR_RS_CONTINUOUS_RX_ENABLE = 4;
	localparam int EUR_RS_ADDRESS_DETECT_ENABLE = 3;
	localparam int EUR_RS_FRAMING_ERROR = 2;
	localparam int EUR_RS_OVERRUN_ERROR = 1;
	localparam int EUR_RS_NINTH = 0;
	// transmit_status_control fields
	localparam int EUR_TS_SYNC = 4;
	localparam int EUR_TS_HSPD = 2;
	// baud_control fields
	localparam int EUR_BC_IDLE = 6;
	localparam int EUR_BC_WIDE = 3;
	localparam int EUR_BC_WAKE = 1;
	// int_control fields
	localparam int EUR_IC_IE = 0;
	localparam int EUR_IC_FLAG = 1;

	// Reset values
	localparam logic [7:0] EUR_RST_RCV_STAT = 8'h00;
	localparam logic [7:0] EUR_RST_TX_STAT = 8'h00;
	localparam logic [7:0] EUR_RST_BAUD_CTL = 8'h00;
	localparam logic [7:0] EUR_RST_DIV = 8'h00;

	// Sampling: first phase after the start edge, last data bit numbers and the tick of the mid-bit vote
	localparam logic [3:0] EUR_MID_TICK = 4'h8;
	localparam logic [3:0] EUR_FIRST_PHASE = 4'h1;
	localparam logic [3:0] EUR_LAST_BIT_8 = 4'h7;
	localparam logic [3:0] EUR_LAST_BIT_9 = 4'h8;
	localparam int EUR_PER_W = 18;

	localparam logic [1:0] EUR_HTRANS_NONSEQ = 2'b10;

	typedef enum logic [1:0] {
		EUR_ST_IDLE = 2'b00,
		EUR_ST_START = 2'b01,
		EUR_ST_DATA = 2'b11,
		EUR_ST_STOP = 2'b10
	} eur_state_e;

	typedef struct packed {
		logic port_enable;
		logic rx_nine_bit_enable;
		logic continuous_rx_enable;
		logic address_detect_enable;
		logic sync_mode;
		logic high_speed_baud;
		logic wide_divisor_select;
		logic wakeup_enable;
		logic rx_int_enable;
	} eur_cfg_s;

	typedef struct packed {
		logic [7:0] data;
		logic rx_ninth_bit;
		logic framing_error;
	} eur_char_s;
endpackage

// file: sim/eur_rx_assertions.sv
`timescale 1ns/1ps
module eur_rx_chk
	import eur_pkg::*;
(
	// Bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Line, power and interrupt
	input wire logic serial_rx_line,
	input wire logic cpu_sleep,
	input wire logic rx_irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic tk, rd, wr, rdd, wp_q;
	logic [7:0] lo_q;
	assign tk = hsel && hready && htrans[1];
	assign rd = tk && !hwrite;
	assign wr = tk && hwrite;
	assign rdd = rd && haddr[7:0] == EUR_OFS_RCV_DATA;
	// Shadow of the divisor low byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= 1'b0;
			lo_q <= 8'h00;
		end else begin
			wp_q <= wr && haddr[7:0] == EUR_OFS_DIV_LO;
			if (wp_q) lo_q <= hwdata[7:0];
		end
	end
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("hrdata upper set");
	chk_rdata_hold: assert property (!rd |=> $stable(hrdata)) else $error("hrdata moved");
	chk_unmapped_zero: assert property (rd && haddr[7:0] > EUR_OFS_INT_CTL |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_div_readback: assert property (rd && haddr[7:0] == EUR_OFS_DIV_LO |=> hrdata[7:0] == $past(lo_q))
		else $error("divisor readback wrong");
	chk_irq_fall: assert property ($fell(rx_irq) |-> $past(rdd) || $past(wr, 2))
		else $error("irq fell without read");
	chk_irq_stands: assert property (rx_irq && !rdd && !wr && !$past(wr) |=> rx_irq)
		else $error("flag lost");
	chk_sleep_quiet: assert property ($rose(rx_irq) && $past(cpu_sleep) && $past(cpu_sleep, 2)
		|-> $past(wr, 2) || !$past(serial_rx_line) || !$past(serial_rx_line, 2)) else $error("rx while asleep");
	cover property ($rose(rx_irq));
	cover property (cpu_sleep && $rose(rx_irq));
	cover property (rd && haddr[7:0] > EUR_OFS_INT_CTL);
endmodule
bind eur_rx eur_rx_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.serial_rx_line(serial_rx_line), .cpu_sleep(cpu_sleep), .rx_irq(rx_irq));

// file: sim/eur_remote_tx.sv
`timescale 1ns/1ps
module eur_remote_tx (
	// Clock
	input wire logic hclk,
	// Line
	output logic serial_rx_line
);
	initial serial_rx_line = 1'b1;
	// Start, nb bits LSB first, stop, two idle bits; a low stop returns to mark early
	task automatic send(input logic [8:0] d, input int nb, input int cyc, input logic stp);
		for (int i = 0; i < nb + 4; i++) begin
			for (int j = 0; j < cyc; j++) begin
				serial_rx_line <= i == 0 ? 1'b0 : i <= nb ? d[i - 1] : i > nb + 1 || stp || j >= cyc * 5 / 8;
				@(posedge hclk);
			end
		end
	endtask
endmodule

// file: sim/test_async_uart_receiver_wakeup.sv
`timescale 1ns/1ps
module test_async_uart_receiver_wakeup;
	import eur_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic cpu_sleep = 1'b0;
	logic hreadyout, hresp, rx_irq, line;
	logic [31:0] hrdata;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int bc = 16;
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] tsv [4] = '{8'h00, 8'h00, 8'h04, 8'h04};
	logic [7:0] bcv [4] = '{8'h00, 8'h08, 8'h08, 8'h00};
	logic [7:0] lov [4] = '{8'h00, 8'h03, 8'h07, 8'h00};
	int bcy [4] = '{64, 64, 32, 16};
	always #25 hclk = ~hclk;
	eur_rx DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.serial_rx_line(line), .cpu_sleep(cpu_sleep), .rx_irq(rx_irq));
	eur_remote_tx remote (.hclk(hclk), .serial_rx_line(line));
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= EUR_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(nm, {24'h0, e}, q);
	endtask
	task automatic irq(input logic e);
		#1;
		chk("rx_irq", {31'h0, e}, {31'h0, rx_irq});
		@(posedge hclk);
	endtask
	function automatic logic [7:0] st(input logic [7:0] c, input logic fe, input logic oe, input logic n9);
		st = c;
		st[EUR_RS_FRAMING_ERROR] = fe;
		st[EUR_RS_OVERRUN_ERROR] = oe;
		st[EUR_RS_NINTH] = n9;
	endfunction
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			$display("timeout");
			close_out();
		end
	end
	initial begin
		logic [8:0] d;
		logic [7:0] c1;
		logic [31:0] q;
		void'($urandom(32'h1f184ae9));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rv[i]) rd("reset value", 8'(i * 4), rv[i]);
		c1 = 8'($urandom);
		wr(EUR_OFS_RCV_DATA, c1);
		rd("data read only", EUR_OFS_RCV_DATA, 8'h00);
		wr(EUR_OFS_DIV_HI, c1);
		rd("divisor high", EUR_OFS_DIV_HI, c1);
		wr(EUR_OFS_DIV_HI, 8'h00);
		$display("registers done");
		wr(EUR_OFS_INT_CTL, 8'h01);
		wr(EUR_OFS_RCV_STAT, 8'h90);
		for (int k = 0; k < 4; k++) begin
			wr(EUR_OFS_TX_STAT, tsv[k]);
			wr(EUR_OFS_BAUD_CTL, bcv[k]);
			wr(EUR_OFS_DIV_LO, lov[k]);
			rd("divisor low", EUR_OFS_DIV_LO, lov[k]);
			bc = bcy[k];
			d = 9'($urandom);
			remote.send(d, 8, bc, 1'b1);
			irq(1'b1);
			rd("data", EUR_OFS_RCV_DATA, d[7:0]);
			irq(1'b0);
		end
		$display("baud rates done");
		c1 = 8'($urandom);
		remote.send({1'b0, c1}, 8, bc, 1'b1);
		remote.send(9'h0a5, 8, bc, 1'b1);
		rd("overrun", EUR_OFS_RCV_STAT, st(8'h90, 1'b0, 1'b1, 1'b0));
		rd("kept data", EUR_OFS_RCV_DATA, c1);
		wr(EUR_OFS_RCV_STAT, 8'h80);
		rd("overrun cleared", EUR_OFS_RCV_STAT, 8'h80);
		wr(EUR_OFS_RCV_STAT, 8'h90);
		d = 9'($urandom);
		remote.send(d, 8, bc, 1'b0);
		irq(1'b1);
		rd("framing", EUR_OFS_RCV_STAT, st(8'h90, 1'b1, 1'b0, 1'b0));
		rd("data", EUR_OFS_RCV_DATA, d[7:0]);
		wr(EUR_OFS_RCV_STAT, 8'h80);
		rd("framing cleared", EUR_OFS_RCV_STAT, 8'h80);
		remote.send(9'($urandom), 8, bc, 1'b1);
		irq(1'b0);
		wr(EUR_OFS_RCV_STAT, 8'h90);
		wr(EUR_OFS_TX_STAT, 8'h14);
		remote.send(9'($urandom), 8, bc, 1'b1);
		irq(1'b0);
		wr(EUR_OFS_TX_STAT, 8'h04);
		$display("errors and enables done");
		wr(EUR_OFS_RCV_STAT, 8'hd8);
		remote.send({1'b0, c1}, 9, bc, 1'b1);
		irq(1'b0);
		d = {1'b1, 8'($urandom)};
		remote.send(d, 9, bc, 1'b1);
		irq(1'b1);
		rd("ninth", EUR_OFS_RCV_STAT, st(8'hd8, 1'b0, 1'b0, 1'b1));
		rd("address", EUR_OFS_RCV_DATA, d[7:0]);
		wr(EUR_OFS_RCV_STAT, 8'hd0);
		d = {1'b0, 8'($urandom)};
		remote.send(d, 9, bc, 1'b1);
		irq(1'b1);
		rd("ninth", EUR_OFS_RCV_STAT, st(8'hd0, 1'b0, 1'b0, 1'b0));
		rd("data", EUR_OFS_RCV_DATA, d[7:0]);
		wr(EUR_OFS_RCV_STAT, 8'h90);
		$display("address detect done");
		cpu_sleep <= 1'b1;
		remote.send(9'($urandom), 8, bc, 1'b1);
		irq(1'b0);
		wr(EUR_OFS_BAUD_CTL, 8'h02);
		rd("wake armed", EUR_OFS_BAUD_CTL, 8'h42);
		remote.send(9'h000, 8, bc, 1'b1);
		irq(1'b1);
		rd("wake cleared", EUR_OFS_BAUD_CTL, 8'h40);
		wr(EUR_OFS_INT_CTL, 8'h00);
		irq(1'b0);
		rd("flag", EUR_OFS_INT_CTL, 8'h02);
		wr(EUR_OFS_INT_CTL, 8'h01);
		bus(1'b0, EUR_OFS_RCV_DATA, 8'h00, q);
		irq(1'b0);
		cpu_sleep <= 1'b0;
		d = 9'($urandom);
		remote.send(d, 8, bc, 1'b1);
		irq(1'b1);
		rd("data", EUR_OFS_RCV_DATA, d[7:0]);
		$display("wake done");
		close_out();
	end
endmodule
